// ===== src/vemr_regs.sv
// two encoder mode registers and the controls they steer
`timescale 1ns/1ps
`default_nettype none
module vemr_regs
  import vemr_pkg::*;
(
  // clock and reset
  input  wire logic                          I_CORE_CLK,
  input  wire logic                          I_RST,
  // register access from the serial slave
  input  wire logic [vemr_pkg::PTR_W-1:0]    I_REG_PTR,
  input  wire logic                          I_REG_WR_STB,
  input  wire logic [7:0]                    I_REG_WR_DATA,
  input  wire logic                          I_REG_RD_STB,
  output logic      [7:0]                    O_REG_RD_DATA,
  output logic                               O_REG_RD_VALID,
  output logic                               O_REG_HIT,
  // video context
  input  wire logic                          I_PAL,
  input  wire logic                          I_SLAVE_MODE,
  input  wire logic                          I_LINE_START,
  input  wire logic                          I_SC_SYNC_PIN,
  // mode controls
  output logic                               O_INTERLACE,
  output logic                               O_CC_ODD,
  output logic                               O_CC_EVEN,
  output logic      [2:0]                    O_DAC_PD,
  output logic                               O_COLOUR_BAR,
  output logic      [9:0]                    O_BAR_WHITE_X10,
  output logic      [9:0]                    O_BAR_BLACK_X10,
  output logic      [6:0]                    O_BAR_SAT_PCT,
  output logic                               O_TIMING_MASTER,
  output logic                               O_SQUARE_PIXEL,
  output logic                               O_SC_PIN_IS_INPUT,
  output logic                               O_SC_RESET,
  output logic                               O_RTC_VALID,
  output logic                               O_RTC_LEVEL,
  output logic      [vemr_pkg::LEN_W-1:0]    O_ACTIVE_PIXELS,
  output logic                               O_LINE_ACTIVE,
  output logic                               O_CHROMA_EN,
  output logic                               O_BURST_EN,
  output logic                               O_LOW_POWER_DAC,
  output logic      [6:0]                    O_DAC_CURRENT_PCT
);
  import vemr_pkg::*;

  logic [7:0]       mode_a_q;
  logic [7:0]       mode_b_q;
  logic             pin_level;
  logic             pin_rise;
  logic             win_active;
  logic [LEN_W-1:0] win_count;
  logic [LEN_W-1:0] len_d;
  logic             ptr_a;
  logic             ptr_b;

  assign ptr_a = (I_REG_PTR == PTR_MODE_A);
  assign ptr_b = (I_REG_PTR == PTR_MODE_B);

  // register writes; reserved bits are stored as the host writes them
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      mode_a_q <= A_RESET;
      mode_b_q <= B_RESET;
    end else if (I_REG_WR_STB) begin
      if (ptr_a) begin
        mode_a_q <= I_REG_WR_DATA;
      end
      if (ptr_b) begin
        mode_b_q <= I_REG_WR_DATA;
      end
    end
  end

  // read port: data one cycle after the strobe, unmapped pointers read zero
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_REG_RD_DATA  <= 8'h00;
      O_REG_RD_VALID <= 1'b0;
      O_REG_HIT      <= 1'b0;
    end else begin
      O_REG_RD_VALID <= I_REG_RD_STB;
      O_REG_HIT      <= (I_REG_RD_STB || I_REG_WR_STB) && (ptr_a || ptr_b);
      if (I_REG_RD_STB) begin
        if (ptr_a) begin
          O_REG_RD_DATA <= mode_a_q;
        end else if (ptr_b) begin
          O_REG_RD_DATA <= mode_b_q;
        end else begin
          O_REG_RD_DATA <= RD_UNMAPPED;
        end
      end
    end
  end

  // field controls from the first register
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_INTERLACE  <= 1'b0;
      O_CC_ODD     <= 1'b0;
      O_CC_EVEN    <= 1'b0;
      O_DAC_PD     <= 3'h0;
      O_COLOUR_BAR <= 1'b0;
    end else begin
      O_INTERLACE  <= mode_a_q[A_INTERLACE];
      O_CC_ODD     <= (mode_a_q[A_CC_HI:A_CC_LO] == CC_ODD) ||
                      (mode_a_q[A_CC_HI:A_CC_LO] == CC_BOTH);
      O_CC_EVEN    <= (mode_a_q[A_CC_HI:A_CC_LO] == CC_EVEN) ||
                      (mode_a_q[A_CC_HI:A_CC_LO] == CC_BOTH);
      O_DAC_PD     <= {mode_a_q[A_DAC_PD_UPHI], mode_a_q[A_DAC_PD_UPLO],
                       mode_a_q[A_DAC_PD_LOW]};
      O_COLOUR_BAR <= mode_a_q[A_COLOUR_BAR];
    end
  end

  // bar levels follow the standard; setup is 7.5 IRE only for NTSC
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_BAR_WHITE_X10 <= 10'h000;
      O_BAR_BLACK_X10 <= 10'h000;
      O_BAR_SAT_PCT   <= 7'h00;
    end else begin
      O_BAR_WHITE_X10 <= BAR_WHITE_X10;
      O_BAR_BLACK_X10 <= I_PAL ? BAR_PAL_X10 : BAR_NTSC_X10;
      O_BAR_SAT_PCT   <= BAR_SAT_PCT;
    end
  end

  // timing mode: bars override slave, square pixel needs true slave timing
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TIMING_MASTER <= 1'b1;
      O_SQUARE_PIXEL  <= 1'b0;
    end else begin
      O_TIMING_MASTER <= !I_SLAVE_MODE || mode_a_q[A_COLOUR_BAR];
      O_SQUARE_PIXEL  <= mode_b_q[B_SQUARE_PIX] && I_SLAVE_MODE &&
                         !mode_a_q[A_COLOUR_BAR];
    end
  end

  // the pin is sampled always; its meaning depends on the genlock bits
  vemr_pin_sync u_pin_sync (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_pin   (I_SC_SYNC_PIN),
    .o_level (pin_level),
    .o_rise  (pin_rise)
  );

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_SC_PIN_IS_INPUT <= 1'b0;
      O_SC_RESET        <= 1'b0;
      O_RTC_VALID       <= 1'b0;
      O_RTC_LEVEL       <= 1'b0;
    end else begin
      O_SC_PIN_IS_INPUT <= mode_b_q[B_PIN_INPUT];
      O_SC_RESET        <= pin_rise && mode_b_q[B_PIN_INPUT] &&
                           !mode_b_q[B_PIN_FUNC];
      O_RTC_VALID       <= mode_b_q[B_PIN_INPUT] && mode_b_q[B_PIN_FUNC];
      O_RTC_LEVEL       <= mode_b_q[B_PIN_INPUT] && mode_b_q[B_PIN_FUNC] &&
                           pin_level;
    end
  end

  // active line length
  always_comb begin
    if (!mode_b_q[B_LINE_LEN]) begin
      len_d = LEN_REC601;
    end else begin
      len_d = I_PAL ? LEN_PAL_470 : LEN_NTSC_470;
    end
  end

  vemr_line_window #(
    .LEN_W (LEN_W)
  ) u_line_window (
    .i_clk        (I_CORE_CLK),
    .i_rst        (I_RST),
    .i_line_start (I_LINE_START),
    .i_length     (len_d),
    .o_active     (win_active),
    .o_count      (win_count)
  );

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ACTIVE_PIXELS <= '0;
      O_LINE_ACTIVE   <= 1'b0;
    end else begin
      O_ACTIVE_PIXELS <= len_d;
      O_LINE_ACTIVE   <= win_active;
    end
  end

  // colour, burst and DAC power
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CHROMA_EN       <= 1'b0;
      O_BURST_EN        <= 1'b0;
      O_LOW_POWER_DAC   <= 1'b0;
      O_DAC_CURRENT_PCT <= 7'h00;
    end else begin
      O_CHROMA_EN       <= mode_b_q[B_CHROMA];
      O_BURST_EN        <= mode_b_q[B_BURST];
      O_LOW_POWER_DAC   <= mode_b_q[B_LOW_POWER];
      O_DAC_CURRENT_PCT <= mode_b_q[B_LOW_POWER] ? DAC_LOW_PCT : DAC_FULL_PCT;
    end
  end

  // checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  property p_interlace;
    (I_REG_WR_STB && ptr_a) |-> ##2 (O_INTERLACE == $past(I_REG_WR_DATA[0], 2));
  endproperty
  a_interlace: assert property (p_interlace) else $error("interlace not following write");

  property p_caption;
    (I_REG_WR_STB && ptr_a && I_REG_WR_DATA[2:1] == CC_EVEN) |-> ##2 (O_CC_EVEN && !O_CC_ODD);
  endproperty
  a_caption: assert property (p_caption) else $error("caption field select wrong");

  property p_dac_pd;
    (I_REG_WR_STB && ptr_a) |-> ##2 (O_DAC_PD == {$past(I_REG_WR_DATA[6:5], 2),
                                                 $past(I_REG_WR_DATA[3], 2)});
  endproperty
  a_dac_pd: assert property (p_dac_pd) else $error("dac power-down bits wrong");

  property p_bar_master;
    O_COLOUR_BAR |-> O_TIMING_MASTER;
  endproperty
  a_bar_master: assert property (p_bar_master) else $error("colour bars without master");

  property p_bar_levels;
    O_COLOUR_BAR && $past(I_PAL) |-> (O_BAR_BLACK_X10 == BAR_PAL_X10);
  endproperty
  a_bar_levels: assert property (p_bar_levels) else $error("PAL bar setup level wrong");

  property p_square;
    O_SQUARE_PIXEL |-> !O_TIMING_MASTER;
  endproperty
  a_square: assert property (p_square) else $error("square pixel outside slave");

  property p_sc_reset;
    (pin_rise && mode_b_q[B_PIN_INPUT] && !mode_b_q[B_PIN_FUNC]) |=> O_SC_RESET ##1 !O_SC_RESET;
  endproperty
  a_sc_reset: assert property (p_sc_reset) else $error("subcarrier reset pulse missing");

  property p_rtc;
    O_SC_RESET |-> !O_RTC_VALID && O_SC_PIN_IS_INPUT;
  endproperty
  a_rtc: assert property (p_rtc) else $error("reset while pin in rtc mode");

  property p_line_len;
    $past(mode_b_q[B_LINE_LEN]) && !$past(I_PAL) |-> (O_ACTIVE_PIXELS == LEN_NTSC_470);
  endproperty
  a_line_len: assert property (p_line_len) else $error("NTSC short line length wrong");

  property p_chroma_burst;
    (I_REG_WR_STB && ptr_b) |-> ##2 ((O_CHROMA_EN == $past(I_REG_WR_DATA[4], 2)) &&
                                    (O_BURST_EN == $past(I_REG_WR_DATA[5], 2)));
  endproperty
  a_chroma_burst: assert property (p_chroma_burst) else $error("chroma or burst enable wrong");

  property p_low_power;
    O_LOW_POWER_DAC |-> (O_DAC_CURRENT_PCT == DAC_LOW_PCT);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power current wrong");

  property p_read_b;
    (I_REG_RD_STB && ptr_b && !I_REG_WR_STB) |=> O_REG_RD_VALID && (O_REG_RD_DATA == mode_b_q);
  endproperty
  a_read_b: assert property (p_read_b) else $error("second register read back wrong");

  property p_read_a;
    (I_REG_RD_STB && ptr_a && !I_REG_WR_STB) |=> O_REG_RD_VALID && (O_REG_RD_DATA == mode_a_q);
  endproperty
  a_read_a: assert property (p_read_a) else $error("first register read back wrong");

  c_bars: cover property (O_COLOUR_BAR && O_TIMING_MASTER);
  c_sc_reset: cover property (O_SC_RESET);
  c_square: cover property (O_SQUARE_PIXEL);
  c_line_end: cover property (O_LINE_ACTIVE ##1 !O_LINE_ACTIVE);
endmodule
`default_nettype wire

// ===== src/vemr_pkg.sv
// constants for the encoder mode register pair
package vemr_pkg;
  // register pointer
  localparam int          PTR_W         = 5;
  localparam logic [4:0]  PTR_MODE_A    = 5'h01;
  localparam logic [4:0]  PTR_MODE_B    = 5'h02;
  localparam logic [7:0]  RD_UNMAPPED   = 8'h00;
  // output_mode_control_a fields
  localparam int          A_INTERLACE   = 0;
  localparam int          A_CC_LO       = 1;
  localparam int          A_CC_HI       = 2;
  localparam int          A_DAC_PD_LOW  = 3;
  localparam int          A_RSVD_ONE    = 4;
  localparam int          A_DAC_PD_UPLO = 5;
  localparam int          A_DAC_PD_UPHI = 6;
  localparam int          A_COLOUR_BAR  = 7;
  localparam logic [7:0]  A_RESET       = 8'h10;
  // output_mode_control_b fields
  localparam int          B_SQUARE_PIX  = 0;
  localparam int          B_PIN_INPUT   = 1;
  localparam int          B_PIN_FUNC    = 2;
  localparam int          B_LINE_LEN    = 3;
  localparam int          B_CHROMA      = 4;
  localparam int          B_BURST       = 5;
  localparam int          B_LOW_POWER   = 6;
  localparam int          B_RSVD_ZERO   = 7;
  localparam logic [7:0]  B_RESET       = 8'h00;
  // caption field selector codes
  localparam logic [1:0]  CC_NONE       = 2'h0;
  localparam logic [1:0]  CC_ODD        = 2'h1;
  localparam logic [1:0]  CC_EVEN       = 2'h2;
  localparam logic [1:0]  CC_BOTH       = 2'h3;
  // active line lengths in pixels
  localparam int          LEN_W         = 10;
  localparam logic [9:0]  LEN_REC601    = 10'h2D0;
  localparam logic [9:0]  LEN_NTSC_470  = 10'h2C6;
  localparam logic [9:0]  LEN_PAL_470   = 10'h2BE;
  // colour bar levels, tenths of IRE / percent
  localparam logic [9:0]  BAR_WHITE_X10 = 10'h3E8;
  localparam logic [9:0]  BAR_NTSC_X10  = 10'h04B;
  localparam logic [9:0]  BAR_PAL_X10   = 10'h000;
  localparam logic [6:0]  BAR_SAT_PCT   = 7'h4B;
  // dac bias current in percent
  localparam logic [6:0]  DAC_FULL_PCT  = 7'h64;
  localparam logic [6:0]  DAC_LOW_PCT   = 7'h37;
endpackage

// ===== src/vemr_pin_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module vemr_pin_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_level <= 1'b0;
      o_rise  <= 1'b0;
    end else begin
      o_rise <= (s2_q == s3_q) && s3_q && !o_level;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/vemr_line_window.sv
// active video window: counts a programmed number of pixels per line
`timescale 1ns/1ps
`default_nettype none
module vemr_line_window #(
  parameter int LEN_W = 10
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_line_start,
  input  wire logic [LEN_W-1:0] i_length,
  output logic                  o_active,
  output logic [LEN_W-1:0]      o_count
);
  // length sampled at line start so a mid-line change waits for next line
  logic [LEN_W-1:0] len_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      len_q    <= '0;
      o_count  <= '0;
      o_active <= 1'b0;
    end else if (i_line_start) begin
      len_q    <= i_length;
      o_count  <= '0;
      o_active <= (i_length != '0);
    end else if (o_active) begin
      if (o_count == len_q - LEN_W'(1)) begin
        o_active <= 1'b0;
      end else begin
        o_count <= o_count + LEN_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/vemr_host.sv
// host model: single-byte writes and reads on the register strobes
`timescale 1ns/1ps
`default_nettype none
module vemr_host
  import vemr_pkg::*;
(
  // clock
  input  wire logic                  i_clk,
  // request
  output logic [vemr_pkg::PTR_W-1:0] o_ptr,
  output logic                       o_wr_stb,
  output logic [7:0]                 o_wr_data,
  output logic                       o_rd_stb,
  // answer
  input  wire logic [7:0]            i_rd_data,
  input  wire logic                  i_rd_valid,
  input  wire logic                  i_hit
);
  initial begin
    o_ptr = '0;
    o_wr_stb = 1'b0;
    o_wr_data = 8'h00;
    o_rd_stb = 1'b0;
  end

  // reserved bits are set here so no caller can break them
  task automatic wr(input logic [4:0] p, input logic [7:0] d, output logic h);
    logic [7:0] v;
    v = d;
    if (p == PTR_MODE_A) v[A_RSVD_ONE] = 1'b1;
    if (p == PTR_MODE_B) v[B_RSVD_ZERO] = 1'b0;
    @(posedge i_clk);
    o_ptr <= p;
    o_wr_data <= v;
    o_wr_stb <= 1'b1;
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    // released data bus shows the inverted byte, not the last byte
    o_wr_data <= ~v;
    #1 h = i_hit;
  endtask

  task automatic rd(input logic [4:0] p, output logic [7:0] d, output logic v,
                    output logic h);
    @(posedge i_clk);
    o_ptr <= p;
    o_rd_stb <= 1'b1;
    @(posedge i_clk);
    o_rd_stb <= 1'b0;
    #1;
    d = i_rd_data;
    v = i_rd_valid;
    h = i_hit;
  endtask
endmodule
`default_nettype wire

// ===== dv/video_encoder_mode_regs_1_2_tb.sv
// self-checking bench for the encoder mode register pair
`timescale 1ns/1ps
`default_nettype none
module video_encoder_mode_regs_1_2_tb;
  import vemr_pkg::*;
  logic       clk, rst, pal, slave, line_start, pin, wr_stb, rd_stb, rd_valid, hit;
  logic [4:0] ptr;
  logic [7:0] wr_data, rd_data;
  logic       interlace, cc_odd, cc_even, bars, master, square, pin_in, sc_reset;
  logic       rtc_valid, rtc_level, line_active, chroma, burst, low_power;
  logic [2:0] dac_pd;
  logic [9:0] white, black, act_pix;
  logic [6:0] sat, cur;
  int         err_count, check_count, sc_count, cycles;

  // 25 MHz core clock; square pixel clock rates are the system's job
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  vemr_regs vemr_regs_i (
    .I_CORE_CLK(clk), .I_RST(rst), .I_REG_PTR(ptr), .I_REG_WR_STB(wr_stb),
    .I_REG_WR_DATA(wr_data), .I_REG_RD_STB(rd_stb), .O_REG_RD_DATA(rd_data),
    .O_REG_RD_VALID(rd_valid), .O_REG_HIT(hit), .I_PAL(pal), .I_SLAVE_MODE(slave),
    .I_LINE_START(line_start), .I_SC_SYNC_PIN(pin), .O_INTERLACE(interlace),
    .O_CC_ODD(cc_odd), .O_CC_EVEN(cc_even), .O_DAC_PD(dac_pd), .O_COLOUR_BAR(bars),
    .O_BAR_WHITE_X10(white), .O_BAR_BLACK_X10(black), .O_BAR_SAT_PCT(sat),
    .O_TIMING_MASTER(master), .O_SQUARE_PIXEL(square), .O_SC_PIN_IS_INPUT(pin_in),
    .O_SC_RESET(sc_reset), .O_RTC_VALID(rtc_valid), .O_RTC_LEVEL(rtc_level),
    .O_ACTIVE_PIXELS(act_pix), .O_LINE_ACTIVE(line_active), .O_CHROMA_EN(chroma),
    .O_BURST_EN(burst), .O_LOW_POWER_DAC(low_power), .O_DAC_CURRENT_PCT(cur)
  );

  vemr_host vemr_host_i (
    .i_clk(clk), .o_ptr(ptr), .o_wr_stb(wr_stb), .o_wr_data(wr_data),
    .o_rd_stb(rd_stb), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .i_hit(hit)
  );

  task automatic results();
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  function automatic logic [9:0] exp_len(input logic [7:0] b, input logic p);
    if (!b[B_LINE_LEN]) return LEN_REC601;
    return p ? LEN_PAL_470 : LEN_NTSC_470;
  endfunction

  task automatic chk_modes(input logic [7:0] a, input logic [7:0] b);
    chk(interlace, a[0], "interlace");
    chk(cc_odd, a[1], "cc odd");
    chk(cc_even, a[2], "cc even");
    chk(dac_pd, {a[6], a[5], a[3]}, "dac pd");
    chk(bars, a[7], "bars");
    chk(white, 10'h3E8, "bar white");
    chk(black, pal ? 10'h000 : 10'h04B, "bar black");
    chk(sat, 7'h4B, "bar sat");
    chk(master, !slave | a[7], "master");
    chk(square, b[0] & slave & !a[7], "square");
    chk(pin_in, b[1], "pin input");
    chk(rtc_valid, b[1] & b[2], "rtc valid");
    chk(act_pix, exp_len(b, pal), "length");
    chk(chroma, b[4], "chroma");
    chk(burst, b[5], "burst");
    chk({low_power, cur}, {b[6], b[6] ? 7'h37 : 7'h64}, "low pwr");
  endtask

  always @(posedge clk) begin
    if (sc_reset === 1'b1) sc_count++;
  end

  // ceiling well above the ~12.4k cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      results();
    end
  end

  initial begin
    logic [7:0] a, b, d;
    logic       h, v;
    int         n;
    rst = 1'b1;
    pal = 1'b0;
    slave = 1'b0;
    line_start = 1'b0;
    pin = 1'b0;
    err_count = 0;
    check_count = 0;
    sc_count = 0;
    cycles = 0;
    void'($urandom(32'hCAA3));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_modes(A_RESET, B_RESET);
    vemr_host_i.rd(PTR_MODE_A, d, v, h);
    chk(d, 8'h10, "reset a");
    vemr_host_i.rd(PTR_MODE_B, d, v, h);
    chk(d, 8'h00, "reset b");
    // caption and genlock codes walk every value; other bits random
    for (int i = 0; i < 16; i++) begin
      a = 8'($urandom());
      b = 8'($urandom());
      a[2:1] = i[1:0];
      b[2:1] = i[3:2];
      @(posedge clk);
      pal <= 1'($urandom());
      slave <= 1'($urandom());
      vemr_host_i.wr(PTR_MODE_A, a, h);
      chk(h, 1'b1, "hit a");
      vemr_host_i.wr(PTR_MODE_B, b, h);
      chk(h, 1'b1, "hit b");
      vemr_host_i.wr(5'(3 + $urandom_range(28)), 8'($urandom()), h);
      chk(h, 1'b0, "hit unmapped");
      repeat (2) @(posedge clk);
      #1;
      chk_modes(a, b);
      vemr_host_i.rd(PTR_MODE_A, d, v, h);
      chk({d, v, h}, {a | 8'h10, 2'h3}, "read a");
      vemr_host_i.rd(PTR_MODE_B, d, v, h);
      chk({d, v, h}, {b & 8'h7F, 2'h3}, "read b");
      vemr_host_i.rd(5'(3 + $urandom_range(28)), d, v, h);
      chk({d, v, h}, 10'h002, "read unmapped");
      sc_count = 0;
      @(posedge clk);
      pin <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk(rtc_level, b[1] & b[2], "rtc level");
      @(posedge clk);
      pin <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk(sc_count, b[1] & !b[2], "sc resets");
      n = 0;
      @(posedge clk);
      line_start <= 1'b1;
      @(posedge clk);
      line_start <= 1'b0;
      repeat (740) begin
        @(posedge clk);
        #1;
        if (line_active === 1'b1) n++;
      end
      chk(10'(n), exp_len(b, pal), "line pixels");
    end
    results();
  end
endmodule
`default_nettype wire
